// ==== dma_status_consts.svh ====
`ifndef DMA_STATUS_CONSTS_SVH
`define DMA_STATUS_CONSTS_SVH

// control_status bit positions
`define CS_CMD_BIT 4
`define CS_INTEN_BIT 6
`define CS_ALERT_BIT 13
`define CS_MEM_BIT 14
`define CS_ERR_BIT 15
`define CS_FLAG_BIT 0
`define CS_WIDTH 16
`define CS_ZERO 16'h0000

// timeout lengths in ns and clock period in ns
`define CLK_PERIOD_NS 20
`define TMO_NATIVE_NS 13000
`define TMO_ADAPTER_NS 38000
`define TMO_NATIVE_CYC (`TMO_NATIVE_NS / `CLK_PERIOD_NS)
`define TMO_ADAPTER_CYC (`TMO_ADAPTER_NS / `CLK_PERIOD_NS)
`define TMO_WIDTH 11
`define TMO_ZERO 11'h000
`define TMO_ONE 11'h001

`endif

// ==== dma_status_pkg.sv ====
package dma_status_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_busy = 2'b01,
      st_drain = 2'b10
   } dma_state_t;
endpackage

// ==== sync_timer_if.sv ====
`timescale 1ns/1ps
interface sync_timer_if;
   logic strobe;
   logic reply;
   logic long_sel;
   logic expired;
   modport owner (output strobe, output reply, output long_sel,
      input expired);
   modport timer (input strobe, input reply, input long_sel,
      output expired);
endinterface

// ==== sync_timer.sv ====
`timescale 1ns/1ps
`include "dma_status_consts.svh"
module sync_timer (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // timing channel
   sync_timer_if.timer tif
);
   logic [`TMO_WIDTH-1:0] count;
   logic [`TMO_WIDTH-1:0] limit;
   logic strobe_q;

   assign limit = tif.long_sel ? `TMO_WIDTH'(`TMO_ADAPTER_CYC) :
      `TMO_WIDTH'(`TMO_NATIVE_CYC);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= tif.strobe;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `TMO_ZERO;
      end else if (tif.strobe && !strobe_q) begin
         count <= `TMO_ZERO;
      end else if (tif.strobe && !tif.reply && count != limit) begin
         count <= count + `TMO_ONE;
      end
   end

   assign tif.expired = tif.strobe && !tif.reply && strobe_q &&
      count == limit;

   a_timer_start: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(tif.strobe) |=> count == `TMO_ZERO)
      else $error("timer did not restart on strobe");

   a_expiry_limit: assert property (@(posedge mclk) disable iff (!rst_n)
      tif.expired |-> count == (tif.long_sel ?
      `TMO_WIDTH'(`TMO_ADAPTER_CYC) : `TMO_WIDTH'(`TMO_NATIVE_CYC)))
      else $error("timer expired at the wrong count");
endmodule

// ==== dma_status_bits.sv ====
// Functional notes
// - writing one to bit 0 sends one command pulse to the user device.
// - with bit 0 set, a read of the shared address returns the error register.
// - an asserted user attention is latched into bit 13.
// - bit 13 clears at the next transfer start or on a written zero.
// - attention during a transfer lets the bus cycle end, then stops DMA.
// - the lamp output follows the attention bit, whatever its cause.
// - bit 14 sets when no sync reply arrives within 13 us or 38 us.
// - bit 14 clears on a written zero or at the next transfer start.
// - a command write that starts a transfer clears the latched bits 13 and 14 only.
// - a power-fail warning ends DMA after the current bus cycle.
// - with interrupts enabled, an error during DMA requests an interrupt.
`timescale 1ns/1ps
`include "dma_status_consts.svh"
module dma_status_bits (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic bus_init,
   // register access
   input wire logic cs_write,
   input wire logic cs_read,
   input wire logic [15:0] cs_wdata,
   output logic [15:0] cs_rdata,
   input wire logic [15:0] error_info_register,
   input wire logic [15:0] other_cs_bits,
   // dma bus cycle
   input wire logic dma_request,
   input wire logic cycle_done,
   input wire logic initiator_sync_strobe,
   input wire logic target_sync_reply,
   output logic bus_owned,
   output logic dma_active,
   // error sources
   input wire logic adapter_select,
   input wire logic multi_cycle_request_error,
   input wire logic power_fail_warning,
   input wire logic parity_fault,
   // user side
   input wire logic user_attention,
   output logic command_pulse,
   output logic attention_lamp,
   output logic interrupt_request
);
   dma_status_pkg::dma_state_t state;
   logic cmd_flag;
   logic alert_flag;
   logic mem_flag;
   logic int_enable;
   logic go_write;
   logic any_error;
   logic stop_req;
   logic err_q;
   sync_timer_if tif ();

   assign tif.strobe = initiator_sync_strobe;
   assign tif.reply = target_sync_reply;
   assign tif.long_sel = adapter_select;

   sync_timer u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .tif(tif)
   );

   assign go_write = cs_write && cs_wdata[`CS_FLAG_BIT];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         command_pulse <= 1'b0;
      end else begin
         command_pulse <= go_write && !bus_init;
      end
   end

   // bus initialize clears the flag and enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_flag <= 1'b0;
         int_enable <= 1'b0;
      end else if (bus_init) begin
         cmd_flag <= 1'b0;
         int_enable <= 1'b0;
      end else if (cs_write) begin
         cmd_flag <= cs_wdata[`CS_FLAG_BIT];
         int_enable <= cs_wdata[`CS_INTEN_BIT];
      end
   end

   // latch attention; set wins over clear
   // clear on start or written zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alert_flag <= 1'b0;
      end else if (bus_init) begin
         alert_flag <= 1'b0;
      end else if (user_attention) begin
         alert_flag <= 1'b1;
      end else if (go_write ||
            (cs_write && !cs_wdata[`CS_ALERT_BIT])) begin
         alert_flag <= 1'b0;
      end
   end

   // cleared by zero write or start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_flag <= 1'b0;
      end else if (bus_init) begin
         mem_flag <= 1'b0;
      end else if (tif.expired) begin
         mem_flag <= 1'b1;
      end else if (go_write ||
            (cs_write && !cs_wdata[`CS_MEM_BIT])) begin
         mem_flag <= 1'b0;
      end
   end

   // latched sources clear on start; live inputs clear at source
   assign any_error = alert_flag || mem_flag || multi_cycle_request_error ||
      power_fail_warning || parity_fault;

   assign attention_lamp = alert_flag;

   // stop after the current bus cycle
   assign stop_req = alert_flag || user_attention || power_fail_warning ||
      mem_flag;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dma_status_pkg::st_idle;
      end else if (bus_init) begin
         state <= dma_status_pkg::st_idle;
      end else begin
         case (state)
            dma_status_pkg::st_idle: begin
               if (go_write && dma_request) begin
                  state <= dma_status_pkg::st_busy;
               end
            end
            dma_status_pkg::st_busy: begin
               if (stop_req || !dma_request) begin
                  state <= dma_status_pkg::st_drain;
               end
            end
            dma_status_pkg::st_drain: begin
               if (cycle_done) begin
                  state <= dma_status_pkg::st_idle;
               end
            end
            default: begin
               state <= dma_status_pkg::st_idle;
            end
         endcase
      end
   end

   assign dma_active = state == dma_status_pkg::st_busy;
   assign bus_owned = state != dma_status_pkg::st_idle;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs_rdata <= `CS_ZERO;
      end else if (cs_read) begin
         if (cmd_flag) begin
            cs_rdata <= error_info_register;
         end else begin
            cs_rdata <= other_cs_bits;
            cs_rdata[`CS_FLAG_BIT] <= 1'b0;
            cs_rdata[`CS_INTEN_BIT] <= int_enable;
            cs_rdata[`CS_ALERT_BIT] <= alert_flag;
            cs_rdata[`CS_MEM_BIT] <= mem_flag;
            cs_rdata[`CS_ERR_BIT] <= any_error;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_request <= 1'b0;
         err_q <= 1'b0;
      end else begin
         err_q <= any_error;
         interrupt_request <= int_enable && any_error && !err_q &&
            bus_owned;
      end
   end

   a_cmd_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      go_write && !bus_init |=> command_pulse ##1 !command_pulse)
      else $error("command pulse missing or too long");
   a_alert_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      user_attention && !bus_init |=> alert_flag && attention_lamp)
      else $error("attention not latched");
   a_alert_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      go_write && !user_attention |=> !alert_flag)
      else $error("attention not cleared on start");
   a_mem_set: assert property (@(posedge mclk) disable iff (!rst_n)
      tif.expired && !bus_init |=> mem_flag)
      else $error("missing memory not flagged");
   a_mem_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_write && !cs_wdata[`CS_MEM_BIT] && !tif.expired |=> !mem_flag)
      else $error("missing memory not cleared");
   a_err_summary: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_read && !cmd_flag |=> cs_rdata[`CS_ERR_BIT] == $past(alert_flag ||
      mem_flag || multi_cycle_request_error || power_fail_warning ||
      parity_fault))
      else $error("summary error wrong");
   a_alt_read: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_read && cmd_flag |=> cs_rdata == $past(error_info_register))
      else $error("alternate register not returned");
   a_stop_drain: assert property (@(posedge mclk) disable iff (!rst_n)
      dma_active && power_fail_warning && !bus_init |=> !dma_active)
      else $error("dma not stopped on power fail");
   a_init_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      bus_init |=> !cmd_flag && !mem_flag && !bus_owned)
      else $error("bus initialize did not clear");
endmodule

// ==== dma_far_side.sv ====
`timescale 1ns/1ps
module dma_far_side (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bus slave and user device
   input wire logic initiator_sync_strobe,
   input wire logic mute,
   input wire logic alert_cmd,
   output logic target_sync_reply,
   output logic user_attention
);
   logic seen;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= 1'b0;
      end else begin
         seen <= initiator_sync_strobe;
      end
   end
   // mute models absent memory
   assign target_sync_reply = seen && initiator_sync_strobe && !mute;
   assign user_attention = alert_cmd;
endmodule

// ==== dma_interface_status_bits_bench.sv ====
`timescale 1ns/1ps
module dma_interface_status_bits_bench;
   localparam logic [15:0] base = 16'h0aa0;
   localparam logic [15:0] alt_word = 16'h5a3c;
   logic mclk = 1'b0, rst_n = 1'b0, bus_init = 1'b0;
   logic cs_write = 1'b0, cs_read = 1'b0, dma_request = 1'b0;
   logic cycle_done = 1'b0, strobe = 1'b0, adapter_select = 1'b0;
   logic multi = 1'b0, pf = 1'b0, parity = 1'b0, mute = 1'b0;
   logic alert_cmd = 1'b0, reply, alert, pulse, lamp, irq, owned, active;
   logic [15:0] cs_wdata = 16'h0000, cs_rdata;
   int n_mismatch = 0, comparisons = 0, k;
   dma_status_bits i_dut (.mclk(mclk), .rst_n(rst_n), .bus_init(bus_init),
      .cs_write(cs_write), .cs_read(cs_read), .cs_wdata(cs_wdata),
      .cs_rdata(cs_rdata), .error_info_register(alt_word),
      .other_cs_bits(base), .dma_request(dma_request),
      .cycle_done(cycle_done), .initiator_sync_strobe(strobe),
      .target_sync_reply(reply), .bus_owned(owned), .dma_active(active),
      .adapter_select(adapter_select),
      .multi_cycle_request_error(multi), .power_fail_warning(pf),
      .parity_fault(parity), .user_attention(alert),
      .command_pulse(pulse), .attention_lamp(lamp),
      .interrupt_request(irq));
   dma_far_side i_far (.mclk(mclk), .rst_n(rst_n),
      .initiator_sync_strobe(strobe), .mute(mute), .alert_cmd(alert_cmd),
      .target_sync_reply(reply), .user_attention(alert));
   initial begin
      forever #10 mclk = ~mclk;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [15:0] d);
      cs_write = 1'b1;
      cs_wdata = d;
      tick(1);
      cs_write = 1'b0;
   endtask
   task automatic rd(input logic [15:0] exp);
      cs_read = 1'b1;
      tick(1);
      cs_read = 1'b0;
      tick(1);
      cmp(cs_rdata, exp);
   endtask
   task automatic end_cycle();
      cycle_done = 1'b1;
      tick(1);
      cycle_done = 1'b0;
      tick(2);
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      tick(4);
      rst_n = 1'b1;
      rd(base);
      wr(16'h0001);
      cmp({15'h0, pulse}, 16'h0001);
      tick(1);
      cmp({15'h0, pulse}, 16'h0000);
      rd(alt_word);
      wr(16'h0000);
      rd(base);
      alert_cmd = 1'b1;
      tick(2);
      alert_cmd = 1'b0;
      cmp({15'h0, lamp}, 16'h0001);
      rd(base | 16'ha000);
      wr(16'h0000);
      rd(base);
      cmp({15'h0, lamp}, 16'h0000);
      // answered strobe, then two short strobes
      strobe = 1'b1;
      tick(700);
      rd(base);
      mute = 1'b1;
      for (int i = 0; i < 2; i++) begin
         strobe = 1'b0;
         tick(2);
         strobe = 1'b1;
         tick(400);
      end
      rd(base);
      for (int a = 0; a < 2; a++) begin
         strobe = 1'b0;
         adapter_select = a[0];
         k = a ? 1900 : 650;
         tick(2);
         strobe = 1'b1;
         tick(k - 12);
         rd(base);
         tick(20);
         rd(base | 16'hc000);
         strobe = 1'b0;
         // second pass clears by a start, then drops the flag only
         wr(a ? 16'h0001 : 16'h0000);
         if (a == 1) begin
            tick(1);
            wr(16'h4000);
         end
         rd(base);
      end
      alert_cmd = 1'b1;
      tick(2);
      alert_cmd = 1'b0;
      dma_request = 1'b1;
      wr(16'h0041);
      cmp({15'h0, pulse}, 16'h0001);
      tick(1);
      wr(16'h0040);
      rd(base | 16'h0040);
      cmp({14'h0, owned, active}, 16'h0003);
      alert_cmd = 1'b1;
      for (k = 0; k < 10 && irq !== 1'b1; k++) tick(1);
      cmp({15'h0, irq}, 16'h0001);
      alert_cmd = 1'b0;
      tick(3);
      // bus still held until the current cycle ends
      cmp({14'h0, owned, active}, 16'h0002);
      end_cycle();
      cmp({14'h0, owned, active}, 16'h0000);
      wr(16'h0001);
      tick(1);
      wr(16'h0000);
      pf = 1'b1;
      tick(3);
      cmp({13'h0, irq, owned, active}, 16'h0002);
      end_cycle();
      cmp({14'h0, owned, active}, 16'h0000);
      for (int s = 0; s < 3; s++) begin
         {multi, pf, parity} = 3'h1 << s;
         tick(2);
         rd(base | 16'h8000);
         {multi, pf, parity} = 3'h0;
         tick(1);
      end
      wr(16'h0001);
      tick(1);
      wr(16'h0000);
      rd(base);
      wr(16'h0041);
      dma_request = 1'b0;
      bus_init = 1'b1;
      tick(1);
      bus_init = 1'b0;
      tick(1);
      cmp({14'h0, owned, active}, 16'h0000);
      rd(base);
      complete_run();
   end
endmodule
